// file: rtl/stm_pkg.sv
`default_nettype none
package stm_pkg;
    // ***************************************
    // Register offsets
    // ***************************************
    localparam logic [7:0] OFS_CTRL_FLAGS = 8'h88;
    localparam logic [7:0] OFS_MODE_SEL = 8'h89;
    localparam logic [7:0] OFS_T0_LOW = 8'h8A;
    localparam logic [7:0] OFS_T1_LOW = 8'h8B;
    localparam logic [7:0] OFS_T0_HIGH = 8'h8C;
    localparam logic [7:0] OFS_T1_HIGH = 8'h8D;
    localparam logic [7:0] OFS_T2_CTRL = 8'hC8;
    localparam logic [7:0] OFS_T2_RLD_LOW = 8'hCA;
    localparam logic [7:0] OFS_T2_RLD_HIGH = 8'hCB;
    localparam logic [7:0] OFS_T2_LOW = 8'hCC;
    localparam logic [7:0] OFS_T2_HIGH = 8'hCD;

    // ***************************************
    // Reset values and counts
    // ***************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] DIV_SLOW_LAST = 4'hB;
    localparam logic PIN_IDLE = 1'b1;

    // ***************************************
    // Types
    // ***************************************
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT = 2'b11
    } stm_mode_t;

    typedef struct packed {
        logic tmr_one_ovf_flag;
        logic tmr_one_run;
        logic tmr_zero_ovf_flag;
        logic tmr_zero_run;
        logic ext_irq_one_flag;
        logic rsv2;
        logic ext_irq_zero_flag;
        logic rsv0;
    } stm_ctrl_t;

    typedef struct packed {
        logic tmr_one_gate_en;
        logic tmr_one_count_sel;
        stm_mode_t tmr_one_mode;
        logic tmr_zero_gate_en;
        logic tmr_zero_count_sel;
        stm_mode_t tmr_zero_mode;
    } stm_modesel_t;

    typedef struct packed {
        logic tmr_two_ovf_flag;
        logic tmr_two_ext_edge_flag;
        logic uart_rx_clk_sel;
        logic uart_tx_clk_sel;
        logic tmr_two_ext_en;
        logic tmr_two_run;
        logic tmr_two_count_sel;
        logic tmr_two_capture_sel;
    } stm_t2ctrl_t;
endpackage : stm_pkg
`default_nettype wire

// file: rtl/stm_timers.sv
// Functional notes
// - Timers zero/one count once per 12 clocks in timer mode.
// - Timer two counts per 12 clocks, or 2 in baud mode.
// - Counter mode counts own pin falling edges.
// - Zero/one overflow flags clear on ack; writes ignored.
// - Pin interrupt flags clear on ack; software read/write.
// - Run bits of timers zero and one start and stop counting.
// - Gate enable lets the pin level gate counting.
// - Count select picks pin edges or internal clock.
// - Mode 00: 5-bit prescaler feeds 8-bit high byte.
// - Mode 01: high and low bytes cascade into one 16-bit counter.
// - Mode 10: low byte counts, reloads from high byte on overflow.
// - Mode 11 splits timer zero; high byte uses timer one run/flag.
// - Timer two flag not set in baud mode; software clears it.
// - Edge flag sets on enabled pin falling edge; software clears it.
// - Baud selects pick timer two or one overflows.
// - Enabled pin falling edge triggers capture or reload while timer two runs, not in baud mode; else ignored.
// - Timer two count select picks pin events or internal clock.
// - Auto-reload mode: overflow sets flag and reloads; pin edge also reloads.
// - Capture mode: overflow sets flag; pin edge captures count.
// - Baud mode ignores capture select and reloads on each overflow.
// - Timer two run bit starts or stops it regardless of other bits.
// - Timer two count and capture/reload inputs share one pin.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module stm_timers (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RD_DATA_O,
    // External pins
    input wire logic TMR_ZERO_PIN_I,
    input wire logic TMR_ONE_PIN_I,
    input wire logic TMR_TWO_PIN_I,
    // Interrupt controller side
    input wire logic EXT_IRQ_ZERO_SET_I,
    input wire logic EXT_IRQ_ONE_SET_I,
    input wire logic TMR_ZERO_ACK_I,
    input wire logic TMR_ONE_ACK_I,
    input wire logic EXT_IRQ_ZERO_ACK_I,
    input wire logic EXT_IRQ_ONE_ACK_I,
    output logic TMR_ZERO_IRQ_O,
    output logic TMR_ONE_IRQ_O,
    output logic TMR_TWO_OVF_IRQ_O,
    output logic TMR_TWO_EXT_IRQ_O,
    output logic EXT_IRQ_ZERO_FLAG_O,
    output logic EXT_IRQ_ONE_FLAG_O,
    // Serial port baud ticks
    output logic UART_RX_TICK_O,
    output logic UART_TX_TICK_O
);
    import stm_pkg::*;

    // ***************************************
    // Registers
    // ***************************************
    stm_ctrl_t ctrl_reg;
    stm_modesel_t mode_reg;
    stm_t2ctrl_t t2ctrl_reg;
    logic [7:0] t0_low_reg, t0_high_reg, t1_low_reg, t1_high_reg;
    logic [7:0] t2_low_reg, t2_high_reg, rld_low_reg, rld_high_reg;
    logic [7:0] t0_low_next, t0_high_next, t1_low_next, t1_high_next;
    logic [7:0] t2_low_next, t2_high_next, rld_low_next, rld_high_next;
    logic [7:0] rd_data_reg;
    logic rx_tick_reg, tx_tick_reg;

    // ***************************************
    // Pin synchronisers and edge detect
    // ***************************************
    logic [2:0] pin_raw;
    logic [2:0] sync1_reg, sync2_reg, sync3_reg, level_reg, level_d_reg;
    logic [2:0] pin_fall;

    assign pin_raw = {TMR_TWO_PIN_I, TMR_ONE_PIN_I, TMR_ZERO_PIN_I};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    sync1_reg[gi] <= PIN_IDLE;
                    sync2_reg[gi] <= PIN_IDLE;
                    sync3_reg[gi] <= PIN_IDLE;
                    level_reg[gi] <= PIN_IDLE;
                    level_d_reg[gi] <= PIN_IDLE;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // Only a level seen twice in a row counts
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        level_reg[gi] <= sync3_reg[gi];
                    end
                    level_d_reg[gi] <= level_reg[gi];
                end
            end
            assign pin_fall[gi] = level_d_reg[gi] & ~level_reg[gi];
        end
    endgenerate

    // ***************************************
    // Prescalers
    // ***************************************
    logic [3:0] div_slow_reg;
    logic div_fast_reg;
    logic tick_slow, tick_fast;

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_slow_reg <= 4'h0;
            div_fast_reg <= 1'b0;
        end else begin
            div_slow_reg <= (div_slow_reg == DIV_SLOW_LAST) ? 4'h0 : div_slow_reg + 4'h1;
            div_fast_reg <= ~div_fast_reg;
        end
    end

    assign tick_slow = (div_slow_reg == DIV_SLOW_LAST);
    assign tick_fast = div_fast_reg;

    // ***************************************
    // Timers zero and one
    // ***************************************
    function automatic logic [16:0] step01(input stm_mode_t m, input logic [7:0] tl,
                                           input logic [7:0] th);
        logic [16:0] r;
        r = {1'b0, th, tl};
        case (m)
            MODE_13BIT: begin
                if (tl[4:0] == 5'h1F) begin
                    r = {(th == 8'hFF), th + 8'h01, tl[7:5], 5'h00};
                end else begin
                    r = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
                end
            end
            MODE_16BIT: begin
                r = {1'b0, th, tl} + 17'h00001;
            end
            MODE_RELOAD8: begin
                if (tl == 8'hFF) begin
                    r = {1'b1, th, th};
                end else begin
                    r = {1'b0, th, tl + 8'h01};
                end
            end
            default: begin
                r = {1'b0, th, tl};
            end
        endcase
        return r;
    endfunction : step01

    logic t0_tick, t1_tick, t0_en, t1_en;
    logic t0_ovf, t1_ovf, t0h_ovf;
    logic [16:0] t0_step, t1_step;
    logic split_mode;

    assign split_mode = (mode_reg.tmr_zero_mode == MODE_SPLIT);
    assign t0_tick = mode_reg.tmr_zero_count_sel ? pin_fall[0] : tick_slow;
    assign t1_tick = mode_reg.tmr_one_count_sel ? pin_fall[1] : tick_slow;
    assign t0_en = t0_tick & ctrl_reg.tmr_zero_run
                   & (~mode_reg.tmr_zero_gate_en | level_reg[0]);
    assign t1_en = t1_tick & ctrl_reg.tmr_one_run
                   & (~mode_reg.tmr_one_gate_en | level_reg[1]);
    assign t0_step = step01(mode_reg.tmr_zero_mode, t0_low_reg, t0_high_reg);
    assign t1_step = step01(mode_reg.tmr_one_mode, t1_low_reg, t1_high_reg);

    always_comb begin
        t0_low_next = t0_low_reg;
        t0_high_next = t0_high_reg;
        t0_ovf = 1'b0;
        t0h_ovf = 1'b0;
        if (split_mode) begin
            if (t0_en) begin
                t0_low_next = t0_low_reg + 8'h01;
                t0_ovf = (t0_low_reg == 8'hFF);
            end
            // High half runs on timer one's run bit
            if (ctrl_reg.tmr_one_run & tick_slow) begin
                t0_high_next = t0_high_reg + 8'h01;
                t0h_ovf = (t0_high_reg == 8'hFF);
            end
        end else if (t0_en) begin
            {t0_ovf, t0_high_next, t0_low_next} = t0_step;
        end
        if (WR_I && ADDR_I == OFS_T0_LOW) begin
            t0_low_next = WR_DATA_I;
        end
        if (WR_I && ADDR_I == OFS_T0_HIGH) begin
            t0_high_next = WR_DATA_I;
        end
    end

    always_comb begin
        t1_low_next = t1_low_reg;
        t1_high_next = t1_high_reg;
        t1_ovf = 1'b0;
        // Timer one holds in mode 11
        if (t1_en && mode_reg.tmr_one_mode != MODE_SPLIT) begin
            {t1_ovf, t1_high_next, t1_low_next} = t1_step;
        end
        if (WR_I && ADDR_I == OFS_T1_LOW) begin
            t1_low_next = WR_DATA_I;
        end
        if (WR_I && ADDR_I == OFS_T1_HIGH) begin
            t1_high_next = WR_DATA_I;
        end
    end

    // ***************************************
    // Timer two
    // ***************************************
    logic baud_mode, t2_tick, t2_ovf, t2_ext_evt;
    logic [15:0] t2_count, t2_rld, t2_count_next, t2_rld_next;

    assign baud_mode = t2ctrl_reg.uart_rx_clk_sel | t2ctrl_reg.uart_tx_clk_sel;
    assign t2_count = {t2_high_reg, t2_low_reg};
    assign t2_rld = {rld_high_reg, rld_low_reg};
    // One shared pin
    assign t2_tick = t2ctrl_reg.tmr_two_count_sel ? pin_fall[2]
                     : (baud_mode ? tick_fast : tick_slow);
    assign t2_ext_evt = pin_fall[2] & t2ctrl_reg.tmr_two_ext_en;

    always_comb begin
        t2_count_next = t2_count;
        t2_rld_next = t2_rld;
        t2_ovf = 1'b0;
        if (t2ctrl_reg.tmr_two_run & t2_tick) begin
            if (t2_count == 16'hFFFF) begin
                t2_ovf = 1'b1;
                if (baud_mode | ~t2ctrl_reg.tmr_two_capture_sel) begin
                    t2_count_next = t2_rld;
                end else begin
                    t2_count_next = 16'h0000;
                end
            end else begin
                t2_count_next = t2_count + 16'h0001;
            end
        end
        // Pin edge needs run, no baud mode
        if (t2_ext_evt & t2ctrl_reg.tmr_two_run & ~baud_mode) begin
            if (t2ctrl_reg.tmr_two_capture_sel) begin
                t2_rld_next = t2_count;
            end else begin
                t2_count_next = t2_rld;
            end
        end
        t2_low_next = t2_count_next[7:0];
        t2_high_next = t2_count_next[15:8];
        rld_low_next = t2_rld_next[7:0];
        rld_high_next = t2_rld_next[15:8];
        if (WR_I && ADDR_I == OFS_T2_LOW) begin
            t2_low_next = WR_DATA_I;
        end
        if (WR_I && ADDR_I == OFS_T2_HIGH) begin
            t2_high_next = WR_DATA_I;
        end
        if (WR_I && ADDR_I == OFS_T2_RLD_LOW) begin
            rld_low_next = WR_DATA_I;
        end
        if (WR_I && ADDR_I == OFS_T2_RLD_HIGH) begin
            rld_high_next = WR_DATA_I;
        end
    end

    // ***************************************
    // Count register update
    // ***************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            t0_low_reg <= RST_BYTE;
            t0_high_reg <= RST_BYTE;
            t1_low_reg <= RST_BYTE;
            t1_high_reg <= RST_BYTE;
            t2_low_reg <= RST_BYTE;
            t2_high_reg <= RST_BYTE;
            rld_low_reg <= RST_BYTE;
            rld_high_reg <= RST_BYTE;
        end else begin
            t0_low_reg <= t0_low_next;
            t0_high_reg <= t0_high_next;
            t1_low_reg <= t1_low_next;
            t1_high_reg <= t1_high_next;
            t2_low_reg <= t2_low_next;
            t2_high_reg <= t2_high_next;
            rld_low_reg <= rld_low_next;
            rld_high_reg <= rld_high_next;
        end
    end

    // ***************************************
    // Control and flag registers
    // ***************************************
    logic wr_ctrl, wr_t2ctrl, tf1_set;

    assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL_FLAGS);
    assign wr_t2ctrl = WR_I && (ADDR_I == OFS_T2_CTRL);
    // Split high half owns timer one's flag
    assign tf1_set = (t1_ovf & ~split_mode) | t0h_ovf;

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_reg <= stm_ctrl_t'(RST_BYTE);
        end else begin
            // Set beats ack; writes ignored
            ctrl_reg.tmr_zero_ovf_flag <= t0_ovf
                | (ctrl_reg.tmr_zero_ovf_flag & ~TMR_ZERO_ACK_I);
            ctrl_reg.tmr_one_ovf_flag <= tf1_set
                | (ctrl_reg.tmr_one_ovf_flag & ~TMR_ONE_ACK_I);
            ctrl_reg.rsv2 <= 1'b0;
            ctrl_reg.rsv0 <= 1'b0;
            if (wr_ctrl) begin
                ctrl_reg.tmr_one_run <= WR_DATA_I[6];
                ctrl_reg.tmr_zero_run <= WR_DATA_I[4];
                ctrl_reg.ext_irq_one_flag <= EXT_IRQ_ONE_SET_I | WR_DATA_I[3];
                ctrl_reg.ext_irq_zero_flag <= EXT_IRQ_ZERO_SET_I | WR_DATA_I[1];
            end else begin
                ctrl_reg.ext_irq_one_flag <= EXT_IRQ_ONE_SET_I
                    | (ctrl_reg.ext_irq_one_flag & ~EXT_IRQ_ONE_ACK_I);
                ctrl_reg.ext_irq_zero_flag <= EXT_IRQ_ZERO_SET_I
                    | (ctrl_reg.ext_irq_zero_flag & ~EXT_IRQ_ZERO_ACK_I);
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode_reg <= stm_modesel_t'(RST_BYTE);
        end else if (WR_I && ADDR_I == OFS_MODE_SEL) begin
            mode_reg <= stm_modesel_t'(WR_DATA_I);
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            t2ctrl_reg <= stm_t2ctrl_t'(RST_BYTE);
        end else begin
            if (wr_t2ctrl) begin
                t2ctrl_reg <= stm_t2ctrl_t'(WR_DATA_I);
            end
            // Hardware only sets; software clears; set wins
            t2ctrl_reg.tmr_two_ovf_flag <= (t2_ovf & ~baud_mode)
                | (wr_t2ctrl ? WR_DATA_I[7] : t2ctrl_reg.tmr_two_ovf_flag);
            t2ctrl_reg.tmr_two_ext_edge_flag <= t2_ext_evt
                | (wr_t2ctrl ? WR_DATA_I[6] : t2ctrl_reg.tmr_two_ext_edge_flag);
        end
    end

    // ***************************************
    // Baud ticks and read port
    // ***************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rx_tick_reg <= 1'b0;
            tx_tick_reg <= 1'b0;
        end else begin
            rx_tick_reg <= t2ctrl_reg.uart_rx_clk_sel ? t2_ovf : t1_ovf;
            tx_tick_reg <= t2ctrl_reg.uart_tx_clk_sel ? t2_ovf : t1_ovf;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rd_data_reg <= RST_BYTE;
        end else if (RD_I) begin
            case (ADDR_I)
                OFS_CTRL_FLAGS: rd_data_reg <= ctrl_reg;
                OFS_MODE_SEL: rd_data_reg <= mode_reg;
                OFS_T0_LOW: rd_data_reg <= t0_low_reg;
                OFS_T1_LOW: rd_data_reg <= t1_low_reg;
                OFS_T0_HIGH: rd_data_reg <= t0_high_reg;
                OFS_T1_HIGH: rd_data_reg <= t1_high_reg;
                OFS_T2_CTRL: rd_data_reg <= t2ctrl_reg;
                OFS_T2_RLD_LOW: rd_data_reg <= rld_low_reg;
                OFS_T2_RLD_HIGH: rd_data_reg <= rld_high_reg;
                OFS_T2_LOW: rd_data_reg <= t2_low_reg;
                OFS_T2_HIGH: rd_data_reg <= t2_high_reg;
                default: rd_data_reg <= RST_BYTE;
            endcase
        end else begin
            rd_data_reg <= RST_BYTE;
        end
    end

    assign RD_DATA_O = rd_data_reg;
    assign TMR_ZERO_IRQ_O = ctrl_reg.tmr_zero_ovf_flag;
    assign TMR_ONE_IRQ_O = ctrl_reg.tmr_one_ovf_flag;
    assign TMR_TWO_OVF_IRQ_O = t2ctrl_reg.tmr_two_ovf_flag;
    assign TMR_TWO_EXT_IRQ_O = t2ctrl_reg.tmr_two_ext_edge_flag;
    assign EXT_IRQ_ZERO_FLAG_O = ctrl_reg.ext_irq_zero_flag;
    assign EXT_IRQ_ONE_FLAG_O = ctrl_reg.ext_irq_one_flag;
    assign UART_RX_TICK_O = rx_tick_reg;
    assign UART_TX_TICK_O = tx_tick_reg;
endmodule : stm_timers
`default_nettype wire

// file: tb/stm_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module stm_pins_model
    import stm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pins: zero, one, two
    output logic [2:0] pins_o
);
    initial pins_o = {3{PIN_IDLE}};

    // Four cycles low, four high
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge clk_i);
            pins_o[idx] <= 1'b0;
            repeat (4) @(posedge clk_i);
            pins_o[idx] <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulse

    task automatic set_pin(input int idx, input logic lvl);
        pins_o[idx] <= lvl;
    endtask : set_pin
endmodule : stm_pins_model
`default_nettype wire

// file: tb/stm_timers_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module stm_timers_assertions
    import stm_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic EXT_IRQ_ZERO_SET_I,
    input wire logic EXT_IRQ_ONE_SET_I,
    input wire logic TMR_ZERO_ACK_I,
    input wire logic EXT_IRQ_ZERO_ACK_I,
    input wire logic TMR_ZERO_IRQ_O,
    input wire logic TMR_TWO_OVF_IRQ_O,
    input wire logic TMR_TWO_EXT_IRQ_O,
    input wire logic EXT_IRQ_ZERO_FLAG_O,
    input wire logic EXT_IRQ_ONE_FLAG_O,
    input wire logic UART_TX_TICK_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    logic wr_ctl, wr_t2, ovf_sw, ovf_clr, edge_sw, edge_clr, baud_any, ext_en_reg;
    logic [1:0] baud_reg;
    assign wr_ctl = WR_I && (ADDR_I == OFS_CTRL_FLAGS);
    assign wr_t2 = WR_I && (ADDR_I == OFS_T2_CTRL);
    assign ovf_sw = wr_t2 && WR_DATA_I[7];
    assign ovf_clr = wr_t2 && !WR_DATA_I[7];
    assign edge_sw = wr_t2 && WR_DATA_I[6];
    assign edge_clr = wr_t2 && !WR_DATA_I[6];
    assign baud_any = |baud_reg;

    // Software-only bits
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            baud_reg <= 2'h0;
            ext_en_reg <= 1'b0;
        end else if (wr_t2) begin
            baud_reg <= WR_DATA_I[5:4];
            ext_en_reg <= WR_DATA_I[3];
        end
    end

    property p_rd_idle; !RD_I |=> RD_DATA_O == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_ext0_set; EXT_IRQ_ZERO_SET_I |=> EXT_IRQ_ZERO_FLAG_O; endproperty
    a_ext0_set: assert property (p_ext0_set) else $error("pin flag zero not set");
    property p_ext0_ack;
        EXT_IRQ_ZERO_ACK_I && !EXT_IRQ_ZERO_SET_I && !wr_ctl |=> !EXT_IRQ_ZERO_FLAG_O;
    endproperty
    a_ext0_ack: assert property (p_ext0_ack) else $error("pin flag zero not cleared");
    property p_ext1_wr;
        wr_ctl && !EXT_IRQ_ONE_SET_I |=> EXT_IRQ_ONE_FLAG_O == $past(WR_DATA_I[3]);
    endproperty
    a_ext1_wr: assert property (p_ext1_wr) else $error("pin flag one write lost");
    property p_t0_clr; $fell(TMR_ZERO_IRQ_O) |-> $past(TMR_ZERO_ACK_I); endproperty
    a_t0_clr: assert property (p_t0_clr) else $error("flag zero fell alone");
    property p_ovf_clr; $fell(TMR_TWO_OVF_IRQ_O) |-> $past(ovf_clr); endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("timer two flag fell alone");
    property p_ovf_baud; $rose(TMR_TWO_OVF_IRQ_O) |-> $past(ovf_sw) || !$past(baud_any); endproperty
    a_ovf_baud: assert property (p_ovf_baud) else $error("timer two flag in baud mode");
    property p_edge_clr; $fell(TMR_TWO_EXT_IRQ_O) |-> $past(edge_clr); endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge flag fell alone");
    property p_edge_set; $rose(TMR_TWO_EXT_IRQ_O) |-> $past(edge_sw) || $past(ext_en_reg); endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge flag while disabled");
    property p_tx_pulse; UART_TX_TICK_O |=> !UART_TX_TICK_O; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tick too wide");

    c_t0_ovf: cover property ($rose(TMR_ZERO_IRQ_O));
    c_edge: cover property ($rose(TMR_TWO_EXT_IRQ_O));
    c_baud: cover property (UART_TX_TICK_O ##2 UART_TX_TICK_O);
endmodule : stm_timers_assertions
`default_nettype wire

// file: tb/stm_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stm_timers_tb;
    import stm_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, t2o_seen = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pre;
    logic [1:0] eset = 2'h0;
    logic [3:0] ack = 4'h0;
    logic [2:0] pin;
    logic irq0, irq1, t2o, t2e, ef0, ef1, rxt, txt;
    logic [7:0] exp_q[$];
    logic [7:0] ofs [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA,
        8'hCB, 8'hCC, 8'hCD, 8'h00};
    int num_errors = 0, tests_run = 0, seed = 40645, n;

    always #20 clk = ~clk;

    stm_pins_model pins (.clk_i(clk), .pins_o(pin));
    stm_timers dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_DATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .TMR_ZERO_PIN_I(pin[0]),
        .TMR_ONE_PIN_I(pin[1]), .TMR_TWO_PIN_I(pin[2]), .EXT_IRQ_ZERO_SET_I(eset[0]),
        .EXT_IRQ_ONE_SET_I(eset[1]), .TMR_ZERO_ACK_I(ack[0]), .TMR_ONE_ACK_I(ack[1]),
        .EXT_IRQ_ZERO_ACK_I(ack[2]), .EXT_IRQ_ONE_ACK_I(ack[3]), .TMR_ZERO_IRQ_O(irq0),
        .TMR_ONE_IRQ_O(irq1), .TMR_TWO_OVF_IRQ_O(t2o), .TMR_TWO_EXT_IRQ_O(t2e),
        .EXT_IRQ_ZERO_FLAG_O(ef0), .EXT_IRQ_ONE_FLAG_O(ef1), .UART_RX_TICK_O(rxt),
        .UART_TX_TICK_O(txt));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    // 12*k run cycles give k ticks
    task automatic timed_run(input logic [7:0] a, input logic [7:0] on, input int k);
        wr_reg(a, on);
        repeat (12 * k - 2) @(posedge clk);
        wr_reg(a, 8'h00);
    endtask : timed_run

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        if (rd_seen)
            check(rdata, exp_q.pop_front());
        rd_seen <= rd;
        t2o_seen <= t2o_seen | t2o;
    end

    initial begin
        #800000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) rd_reg(ofs[i], 8'h00);
        $display("test reset values done");
        wr_reg(OFS_CTRL_FLAGS, 8'hFF);
        rd_reg(OFS_CTRL_FLAGS, 8'h5A);
        check({6'h00, ef1, ef0}, 8'h03);
        ack <= 4'h4;
        @(posedge clk);
        ack <= 4'h0;
        eset <= 2'h2;
        @(posedge clk);
        eset <= 2'h1;
        @(posedge clk);
        check({6'h00, ef1, ef0}, 8'h02);
        eset <= 2'h0;
        wr_reg(OFS_CTRL_FLAGS, 8'h00);
        $display("test control flags done");
        pre = 8'($random(seed)) & 8'hF0;
        wr_reg(OFS_MODE_SEL, 8'h11);
        wr_reg(OFS_T0_LOW, pre);
        wr_reg(OFS_T1_LOW, 8'h00);
        timed_run(OFS_CTRL_FLAGS, 8'h50, 5);
        rd_reg(OFS_T0_LOW, pre + 8'h05);
        rd_reg(OFS_T1_LOW, 8'h05);
        wr_reg(OFS_MODE_SEL, 8'h22);
        for (int i = 0; i < 4; i++) wr_reg(OFS_T0_LOW + 8'(i), 8'hFE);
        timed_run(OFS_CTRL_FLAGS, 8'h50, 3);
        rd_reg(OFS_T0_LOW, 8'hFF);
        rd_reg(OFS_T1_LOW, 8'hFF);
        check({6'h00, irq1, irq0}, 8'h03);
        ack <= 4'h3;
        @(posedge clk);
        ack <= 4'h0;
        @(posedge clk);
        check({6'h00, irq1, irq0}, 8'h00);
        wr_reg(OFS_MODE_SEL, 8'h00);
        wr_reg(OFS_T0_LOW, 8'h1E);
        wr_reg(OFS_T0_HIGH, 8'h00);
        timed_run(OFS_CTRL_FLAGS, 8'h50, 3);
        rd_reg(OFS_T0_LOW, 8'h01);
        rd_reg(OFS_T0_HIGH, 8'h01);
        wr_reg(OFS_MODE_SEL, 8'h03);
        wr_reg(OFS_T0_LOW, 8'h00);
        wr_reg(OFS_T0_HIGH, 8'h00);
        timed_run(OFS_CTRL_FLAGS, 8'h40, 5);
        rd_reg(OFS_T0_HIGH, 8'h05);
        rd_reg(OFS_T0_LOW, 8'h00);
        $display("test timer modes done");
        wr_reg(OFS_MODE_SEL, 8'h05);
        wr_reg(OFS_T0_LOW, 8'h00);
        wr_reg(OFS_CTRL_FLAGS, 8'h10);
        pins.pulse(0, 4);
        repeat (8) @(posedge clk);
        wr_reg(OFS_CTRL_FLAGS, 8'h00);
        rd_reg(OFS_T0_LOW, 8'h04);
        wr_reg(OFS_MODE_SEL, 8'h09);
        wr_reg(OFS_T0_LOW, 8'h00);
        pins.set_pin(0, 1'b0);
        repeat (8) @(posedge clk);
        timed_run(OFS_CTRL_FLAGS, 8'h10, 5);
        rd_reg(OFS_T0_LOW, 8'h00);
        pins.set_pin(0, 1'b1);
        repeat (8) @(posedge clk);
        timed_run(OFS_CTRL_FLAGS, 8'h10, 5);
        rd_reg(OFS_T0_LOW, 8'h05);
        $display("test counter and gate done");
        wr_reg(OFS_T2_RLD_LOW, 8'h34);
        wr_reg(OFS_T2_RLD_HIGH, 8'h12);
        wr_reg(OFS_T2_LOW, 8'hFE);
        wr_reg(OFS_T2_HIGH, 8'hFF);
        timed_run(OFS_T2_CTRL, 8'h04, 2);
        rd_reg(OFS_T2_LOW, 8'h34);
        rd_reg(OFS_T2_HIGH, 8'h12);
        check({7'h00, t2o_seen}, 8'h01);
        wr_reg(OFS_T2_CTRL, 8'h00);
        check({7'h00, t2o}, 8'h00);
        wr_reg(OFS_T2_LOW, 8'h00);
        wr_reg(OFS_T2_CTRL, 8'h06);
        pins.pulse(2, 1);
        repeat (8) @(posedge clk);
        check({7'h00, t2e}, 8'h00);
        rd_reg(OFS_T2_LOW, 8'h01);
        wr_reg(OFS_T2_CTRL, 8'h0E);
        pins.pulse(2, 1);
        repeat (8) @(posedge clk);
        check({7'h00, t2e}, 8'h01);
        wr_reg(OFS_T2_CTRL, 8'h00);
        check({7'h00, t2e}, 8'h00);
        wr_reg(OFS_T2_LOW, 8'h00);
        wr_reg(OFS_T2_HIGH, 8'h00);
        wr_reg(OFS_T2_CTRL, 8'h0D);
        pins.pulse(2, 1);
        repeat (8) @(posedge clk);
        rd_reg(OFS_T2_RLD_HIGH, 8'h00);
        for (int i = 0; i < 4; i++) wr_reg(OFS_T2_RLD_LOW + 8'(i), 8'hFF);
        wr_reg(OFS_T2_CTRL, 8'h34);
        repeat (10) @(posedge clk);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += int'(txt) + int'(rxt);
        end
        check(8'(n), 8'h28);
        check({7'h00, t2o}, 8'h00);
        $display("test timer two done");
        repeat (4) @(posedge clk);
        report_and_stop;
    end
endmodule : stm_timers_tb

bind stm_timers stm_timers_assertions u_chk (.*);
`default_nettype wire
